// ---- passive_config_load_port.sv ----
// Device side of the passive configuration load port
`timescale 1ns/10ps
`include "cfg_load_consts.svh"

// What this block does
// - Request low drives fault and load-complete low within 800 ns.
// - Fault released within 40 us after request returns high.
// - Own fault low pulse lasts 10 to 40 us.
// - User mode 6 to 20 us after done, or 136 user clocks.
// - Byte-parallel mode takes a whole byte each clock cycle.
// - Request rising edge starts loading; load-complete driven low.
// - No transfer until both request and fault lines released and high.
// - Detected error drives fault line low, resetting device and loader.
// - Auto restart releases fault after timeout; else waits request pulse.
// - Completion releases load-complete line, deselecting the loader.
// - Initialization runs on internal oscillator unless the user clock is selected, stopped afterwards.
// - Processor parallel raw formats raise done one byte early.
// - Finished device asserts chain-enable output to next device.
// - Wired done and fault lines make the chain act together.
module passive_config_load_port #(
   parameter int FRAME_LEN = `FRAME_LEN_DEF
) (
   input  wire logic                       mclk_i,
   input  wire logic                       sys_rst_i,
   input  wire logic                       cfg_clock_i,
   input  wire logic                       cfg_request_n_i,
   input  wire logic                       fault_line_i,
   output logic                            fault_line_oe_n_o,
   input  wire logic                       load_done_line_i,
   output logic                            load_done_oe_n_o,
   input  wire logic                       chain_enable_in_n_i,
   output logic                            chain_enable_out_n_o,
   input  wire logic                       byte_parallel_mode_i,
   input  wire logic                       raw_format_i,
   input  wire logic                       auto_restart_i,
   input  wire logic                       use_user_clock_i,
   input  wire logic                       user_clock_i,
   input  wire logic [`BYTE_W-1:0]         data_i,
   input  wire logic                       frame_error_i,
   output logic                            init_osc_on_o,
   output logic                            user_mode_o,
   output logic [`BYTE_W-1:0]              last_byte_o,
   output logic                            error_seen_o
);
   import cfg_load_pkg::*;

   // Counters are 16 bits wide; a frame needs at least two units
   if (FRAME_LEN < 2 || FRAME_LEN > 65535) begin : g_bad_len
      $error("FRAME_LEN out of range");
   end

   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_LEN - 1);
   localparam logic [CNT_W-1:0] STATUS_CYC = CNT_W'(`STATUS_LOW_CYC);
   localparam logic [CNT_W-1:0] OSC_CYC    = CNT_W'(`INIT_OSC_CYC);
   localparam logic [CNT_W-1:0] USR_EDGES  = CNT_W'(`USR_INIT_EDGES);

   // ==========================================================
   // Input synchronisers
   logic [1:0] req_s, flt_s, done_s, ce_s, usr_s, auto_s, ferr_s;
   logic       usr_q;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         req_s  <= 2'h0;
         flt_s  <= 2'h0;
         done_s <= 2'h0;
         ce_s   <= 2'h3;
         usr_s  <= 2'h0;
         auto_s <= 2'h0;
         ferr_s <= 2'h0;
         usr_q  <= 1'b0;
      end else begin
         req_s  <= {req_s[0], cfg_request_n_i};
         flt_s  <= {flt_s[0], fault_line_i};
         done_s <= {done_s[0], load_done_line_i};
         ce_s   <= {ce_s[0], chain_enable_in_n_i};
         usr_s  <= {usr_s[0], user_clock_i};
         auto_s <= {auto_s[0], auto_restart_i};
         ferr_s <= {ferr_s[0], frame_error_i};
         usr_q  <= usr_s[1];
      end
   end
   wire req_hi   = req_s[1];
   wire flt_hi   = flt_s[1];
   wire done_hi  = done_s[1];
   wire usr_rise = usr_s[1] & ~usr_q;

   // ==========================================================
   // Link-domain load logic
   logic             load_arm;       // level from main domain
   logic [CNT_W-1:0] unit_cnt;
   logic [2:0]       bit_idx;
   logic             frame_full;     // level to main domain
   logic             early_done;     // level to main domain
   // Link clock stands still between frames, so a synchroniser there
   // would swallow the first edges of a frame. Arm is steady at least
   // a microsecond before the first edge, and its fall clears the
   // counters while the clock is stopped, so a stale full never lingers.
   wire link_clr = sys_rst_i | ~load_arm;
   always_ff @(posedge cfg_clock_i or posedge link_clr) begin
      if (link_clr) begin
         unit_cnt   <= '0;
         bit_idx    <= 3'h0;
         frame_full <= 1'b0;
         early_done <= 1'b0;
      end else if (!frame_full) begin
         if (byte_parallel_mode_i) begin
            unit_cnt <= unit_cnt + 1'b1;
            if (unit_cnt == FRAME_LAST)
               frame_full <= 1'b1;
            if (raw_format_i && unit_cnt == FRAME_LAST - 1'b1)
               early_done <= 1'b1;
         end else begin
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == 3'h7) begin
               unit_cnt <= unit_cnt + 1'b1;
               if (unit_cnt == FRAME_LAST)
                  frame_full <= 1'b1;
            end
         end
      end
   end

   // Not cleared with the counters, so it can be read after loading
   always_ff @(posedge cfg_clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         last_byte_o <= '0;
      end else if (load_arm && !frame_full) begin
         // Serial bits arrive LSB first on data bit 0
         if (byte_parallel_mode_i)
            last_byte_o <= data_i;
         else
            last_byte_o[bit_idx] <= data_i[0];
      end
   end

   logic [1:0] full_s, early_s;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         full_s  <= 2'h0;
         early_s <= 2'h0;
      end else begin
         full_s  <= {full_s[0], frame_full};
         early_s <= {early_s[0], early_done};
      end
   end
   wire load_finished = full_s[1] | early_s[1];

   // ==========================================================
   // Main sequencer
   cfg_state_e       state;
   logic [CNT_W-1:0] tmr;
   logic             req_q;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         req_q <= 1'b0;
      else
         req_q <= req_hi;
   end
   wire req_rise = req_hi & ~req_q;

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state        <= ST_IDLE;
         tmr          <= '0;
         error_seen_o <= 1'b0;
      end else if (!req_hi) begin
         state <= ST_CLEAR;
         tmr   <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (req_rise)
                  state <= ST_CLEAR;
            end
            ST_CLEAR: begin
               // Own fault pulse, length between min and max
               tmr <= tmr + 1'b1;
               if (tmr >= STATUS_CYC - 1'b1) begin
                  state        <= ST_LOAD;
                  tmr          <= '0;
                  error_seen_o <= 1'b0;
               end
            end
            ST_LOAD: begin
               if (ferr_s[1] || (!flt_hi && load_arm)) begin
                  state        <= ST_FAULT;
                  tmr          <= '0;
                  error_seen_o <= 1'b1;
               end else if (load_finished)
                  state <= ST_INIT;
            end
            ST_FAULT: begin
               // Without auto restart only a request pulse gets out
               if (auto_s[1]) begin
                  tmr <= tmr + 1'b1;
                  if (tmr >= STATUS_CYC - 1'b1) begin
                     state <= ST_LOAD;
                     tmr   <= '0;
                  end
               end
            end
            ST_INIT: begin
               // Wired done line: wait until every device let go
               if (done_hi) begin
                  if (use_user_clock_i) begin
                     if (usr_rise) begin
                        tmr <= tmr + 1'b1;
                        if (tmr == USR_EDGES - 1'b1)
                           state <= ST_USER;
                     end
                  end else begin
                     tmr <= tmr + 1'b1;
                     if (tmr == OSC_CYC - 1'b1)
                        state <= ST_USER;
                  end
               end
            end
            ST_USER: state <= ST_USER;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Loading armed only with chain enable low and fault line high
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         load_arm <= 1'b0;
      else
         load_arm <= (state == ST_LOAD) && !ce_s[1] && flt_hi;
   end

   // ==========================================================
   // Pin drive: open-drain, enable low means pulling low
   // Synced request still meets the 800 ns limit with room to spare
   always_comb begin
      fault_line_oe_n_o = !(!req_hi || state == ST_CLEAR ||
                            state == ST_FAULT);
      load_done_oe_n_o  = !(!req_hi || state == ST_CLEAR ||
                            state == ST_LOAD || state == ST_FAULT);
   end
   assign chain_enable_out_n_o = !(state == ST_INIT ||
                                   state == ST_USER);
   assign init_osc_on_o = (state == ST_INIT) && done_hi &&
                          !use_user_clock_i;
   assign user_mode_o   = (state == ST_USER);

   // ==========================================================
   // Checks
   property p_req_low_drives;
      @(posedge mclk_i) disable iff (sys_rst_i)
      !req_hi |-> !fault_line_oe_n_o ##0 !load_done_oe_n_o;
   endproperty
   a_req_low_drives: assert property (p_req_low_drives)
      else $error("request low but lines not pulled");

   // Length of the present low stretch on the fault enable, saturating
   logic [CNT_W-1:0] flt_low_cnt;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         flt_low_cnt <= '0;
      else if (fault_line_oe_n_o)
         flt_low_cnt <= '0;
      else if (flt_low_cnt != '1)
         flt_low_cnt <= flt_low_cnt + 1'b1;
   end

   property p_fault_min;
      @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(fault_line_oe_n_o) && state != ST_IDLE |->
         flt_low_cnt >= STATUS_CYC;
   endproperty
   a_fault_min: assert property (p_fault_min)
      else $error("fault pulse too short");

   property p_fault_release;
      @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(req_hi) |-> ##[1:210] fault_line_oe_n_o;
   endproperty
   a_fault_release: assert property (p_fault_release)
      else $error("fault not released in time");

   property p_done_on_finish;
      @(posedge mclk_i) disable iff (sys_rst_i)
      state == ST_LOAD && load_finished && req_hi && !ferr_s[1]
         && !(!flt_hi && load_arm) |=> load_done_oe_n_o;
   endproperty
   a_done_on_finish: assert property (p_done_on_finish)
      else $error("done line not released");

   property p_chain_out;
      @(posedge mclk_i) disable iff (sys_rst_i)
      state == ST_INIT |-> !chain_enable_out_n_o;
   endproperty
   a_chain_out: assert property (p_chain_out)
      else $error("chain enable not asserted");

   property p_error_fault;
      @(posedge mclk_i) disable iff (sys_rst_i)
      state == ST_LOAD && ferr_s[1] && req_hi |=> !fault_line_oe_n_o;
   endproperty
   a_error_fault: assert property (p_error_fault)
      else $error("error did not pull fault line");

   property p_hold_fault;
      @(posedge mclk_i) disable iff (sys_rst_i)
      state == ST_FAULT && !auto_s[1] && req_hi |=> state == ST_FAULT;
   endproperty
   a_hold_fault: assert property (p_hold_fault)
      else $error("fault left without restart");

   property p_osc_user;
      @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(user_mode_o) && !use_user_clock_i |->
         $past(init_osc_on_o);
   endproperty
   a_osc_user: assert property (p_osc_user)
      else $error("user mode without oscillator init");

   property p_osc_off;
      @(posedge mclk_i) disable iff (sys_rst_i)
      user_mode_o |-> !init_osc_on_o;
   endproperty
   a_osc_off: assert property (p_osc_off)
      else $error("oscillator still running");

   c_load:  cover property (@(posedge mclk_i) $rose(state == ST_INIT));
   c_user:  cover property (@(posedge mclk_i) $rose(user_mode_o));
   c_fault: cover property (@(posedge mclk_i) $rose(state == ST_FAULT));
   c_usrck: cover property (@(posedge mclk_i)
                            $rose(user_mode_o) && use_user_clock_i);
endmodule // passive_config_load_port

// ---- cfg_load_consts.svh ----
// Timing and layout constants for the passive configuration load port
`ifndef CFG_LOAD_CONSTS_SVH
`define CFG_LOAD_CONSTS_SVH
`define CLK_PERIOD_NS        50
`define CF2ST0_MAX_NS        800
`define CF2ST0_CYC           ((`CF2ST0_MAX_NS) / (`CLK_PERIOD_NS))
`define STATUS_MIN_US        10
`define STATUS_MAX_US        40
`define STATUS_LOW_CYC       (((`STATUS_MIN_US) * 1000 + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define CD2UM_MIN_US         6
`define CD2UM_MAX_US         20
`define OSC_PERIOD_NS        100
`define INIT_OSC_CYC         (((`CD2UM_MIN_US) * 1000 + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define USR_INIT_EDGES       136
`define BYTE_W               8
`define FRAME_LEN_DEF        64
`endif

// ---- cfg_load_pkg.sv ----
// Types for the passive configuration load port
package cfg_load_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CLEAR,
      ST_FAULT,
      ST_LOAD,
      ST_INIT,
      ST_USER
   } cfg_state_e;
endpackage

// ---- cfg_loader_model.sv ----
// Loader model: configuration clock, data and output-enable line
`timescale 1ns/10ps
module cfg_loader_model #(
   parameter bit POWER_ON_DELAY_SELECT = 1'b1
) (
   output logic       cfg_clock_o,
   output logic [7:0] data_o,
   output logic       loader_oe_n_o
);
   // ==========================================================
   // Idle levels
   localparam int POR_NS = POWER_ON_DELAY_SELECT ? 2000000 : 100000000;

   initial begin
      cfg_clock_o   = 1'b0;
      data_o        = 8'h00;
      // Enable held low until the loader's own supply has settled
      loader_oe_n_o = 1'b0;
      #(POR_NS) loader_oe_n_o = 1'b1;
   end

   // ==========================================================
   // One frame; clock only runs inside it, 125 ns period
   task automatic send(input logic [7:0] b [4], input logic par);
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < (par ? 1 : 8); k++) begin
            data_o = par ? b[i] : {~data_o[7:1], b[i][k]};
            #62.5 cfg_clock_o = 1'b1;
            #62.5 cfg_clock_o = 1'b0;
         end
      end
      // Released data flips so a stale value never matches
      data_o = ~data_o;
   endtask

   // ==========================================================
   // Short low pulse when completion was never seen
   task automatic pulse_oe();
      loader_oe_n_o = 1'b0;
      #3000 loader_oe_n_o = 1'b1;
   endtask
endmodule // cfg_loader_model

// ---- test_passive_config_load_port.sv ----
// Self-checking bench for the passive configuration load port
`timescale 1ns/10ps
module test_passive_config_load_port;
   logic       mclk, sys_rst, req_n, par, auto_rst, ferr;
   logic       cfg_clock, loader_oe_n, fault_oe_n, done_oe_n;
   logic       chain_n, osc_on, user_mode, error_seen;
   logic       raw, use_usr, usr_clk;
   logic [7:0] data, last_byte;
   int         failures, tests_run;

   // ==========================================================
   // Wired lines with pull-ups
   wire fault_line = fault_oe_n & loader_oe_n;
   wire done_line  = done_oe_n;

   passive_config_load_port #(.FRAME_LEN(4)) u_dut (
      .mclk_i(mclk), .sys_rst_i(sys_rst), .cfg_clock_i(cfg_clock),
      .cfg_request_n_i(req_n), .fault_line_i(fault_line),
      .fault_line_oe_n_o(fault_oe_n), .load_done_line_i(done_line),
      .load_done_oe_n_o(done_oe_n), .chain_enable_in_n_i(1'b0),
      .chain_enable_out_n_o(chain_n), .byte_parallel_mode_i(par),
      .raw_format_i(raw), .auto_restart_i(auto_rst),
      .use_user_clock_i(use_usr), .user_clock_i(usr_clk), .data_i(data),
      .frame_error_i(ferr), .init_osc_on_o(osc_on),
      .user_mode_o(user_mode), .last_byte_o(last_byte),
      .error_seen_o(error_seen));

   cfg_loader_model u_model (.cfg_clock_o(cfg_clock), .data_o(data),
      .loader_oe_n_o(loader_oe_n));

   // ==========================================================
   // Helpers
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #5;
   endtask

   task automatic check(input string what, input logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Bounded wait; a spent bound ends the run
   task automatic wait_lvl(ref logic s, input logic v, input int lim,
                           output int n);
      n = 0;
      while (s !== v && n < lim) begin
         tick(1);
         n++;
      end
      if (s !== v) begin
         failures++;
         $display("wrong value wait level expected %h seen %h", v, s);
         wrap_up();
      end
   endtask

   // ==========================================================
   // Request pulse, clear phase and settle time
   task automatic start_load();
      int n;
      req_n = 1'b0;
      tick(2);
      check("fault oe low", fault_oe_n, 1'b0);
      check("done oe low", done_oe_n, 1'b0);
      tick(798);
      req_n = 1'b1;
      tick(4);
      wait_lvl(fault_oe_n, 1'b1, 900, n);
      check("fault pulse", (n + 4 >= 200 && n + 4 <= 800), 1'b1);
      check("done held low", done_oe_n, 1'b0);
      // Loader waits out both settle times before clocking
      tick(800);
   endtask

   // ==========================================================
   // Scenarios
   task automatic load_frame(input logic p, input logic [7:0] b [4]);
      int n;
      par = p;
      auto_rst = 1'b1;
      start_load();
      u_model.send(b, p);
      wait_lvl(done_oe_n, 1'b1, 20, n);
      check("chain out", chain_n, 1'b0);
      check("last byte", last_byte, b[3]);
      // Done line passes two sync stages before the oscillator starts
      tick(2);
      check("osc on", osc_on, 1'b1);
      wait_lvl(user_mode, 1'b1, 500, n);
      check("init time", (n + 2 >= 120 && n + 2 <= 400), 1'b1);
      check("osc off", osc_on, 1'b0);
      check("no error", error_seen, 1'b0);
   endtask

   task automatic error_case(input logic a);
      int n;
      par = 1'b1;
      auto_rst = a;
      start_load();
      ferr = 1'b1;
      wait_lvl(fault_oe_n, 1'b0, 10, n);
      tick(1);
      ferr = 1'b0;
      check("error flag", error_seen, 1'b1);
      if (a) begin
         wait_lvl(fault_oe_n, 1'b1, 900, n);
         check("restart", (n >= 195 && n <= 800), 1'b1);
      end else begin
         tick(1000);
         check("fault kept", fault_oe_n, 1'b0);
      end
   endtask

   // Raw format finishes a byte early; start-up on the user clock
   task automatic special_case();
      int n;
      par = 1'b1;
      raw = 1'b1;
      use_usr = 1'b1;
      auto_rst = 1'b1;
      start_load();
      u_model.send('{8'h11, 8'h22, 8'h33, 8'h44}, 1'b1);
      check("early done", done_oe_n, 1'b1);
      tick(2);
      check("last byte raw", last_byte, 8'h44);
      check("osc idle", osc_on, 1'b0);
      // 136 user clock periods of six main cycles each
      wait_lvl(user_mode, 1'b1, 900, n);
      check("user clocks", (n + 2 >= 805 && n + 2 <= 830), 1'b1);
      raw = 1'b0;
      use_usr = 1'b0;
   endtask

   task automatic oe_pulse_case();
      int n;
      auto_rst = 1'b1;
      start_load();
      fork
         u_model.pulse_oe();
         wait_lvl(fault_oe_n, 1'b0, 40, n);
      join
      check("oe error", error_seen, 1'b1);
      wait_lvl(fault_oe_n, 1'b1, 900, n);
   endtask

   // ==========================================================
   // Clock, reset and sequence
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // User start-up clock, 300 ns period, well below the main clock
   initial begin
      usr_clk = 1'b0;
      forever #150 usr_clk = ~usr_clk;
   end

   initial begin
      sys_rst = 1'b1;
      req_n = 1'b0;
      par = 1'b0;
      auto_rst = 1'b1;
      ferr = 1'b0;
      raw = 1'b0;
      use_usr = 1'b0;
      failures = 0;
      tests_run = 0;
      repeat (4) @(posedge mclk);
      #5 sys_rst = 1'b0;
      tick(2);
      // Loader keeps its enable low through its 2 ms power-on delay
      tick(40000);
      load_frame(1'b0, '{8'ha5, 8'h3c, 8'h81, 8'h7e});
      load_frame(1'b1, '{8'h01, 8'hfe, 8'h5a, 8'hc3});
      error_case(1'b1);
      error_case(1'b0);
      oe_pulse_case();
      load_frame(1'b1, '{8'h10, 8'h20, 8'h40, 8'h80});
      special_case();
      wrap_up();
   end
endmodule // test_passive_config_load_port
